// ==== pss_defines.vh ====
// Purpose: Constants for the status summary register bank.
// Assumes: Command codes are byte wide, as carried by the serial bus engine.
// Notes: Included by the status bank design file only.
`ifndef PSS_DEFINES_VH
`define PSS_DEFINES_VH
`define PSS_CMD_SUMMARY_BYTE  8'h78
`define PSS_CMD_SUMMARY_WORD  8'h79
`define PSS_CMD_OUTPUT_STAT   8'h7A
`define PSS_CMD_OUT_CUR_STAT  8'h7B
`define PSS_BIT_BUSY          7
`define PSS_BIT_GATE_OFF      6
`define PSS_BIT_VIN_UV        3
`define PSS_BIT_TEMP          2
`define PSS_BIT_CML           1
`define PSS_BIT_OTHER         0
`define PSS_BIT_OUT_SUM       15
`define PSS_BIT_IOUT_SUM      14
`define PSS_BIT_INPUT_SUM     13
`define PSS_BIT_VENDOR_SUM    12
`define PSS_BIT_PG_LOW        11
`define PSS_BIT_UNKNOWN       8
`define PSS_BIT_OUT_UV_WARN   5
`define PSS_WORD_RESET        16'h0800
`define PSS_BYTE_RESET        8'h00
`endif

// ==== pss_latch_bit.v ====
// Purpose: One sticky status flag.
// Assumes: Fault input is a level synchronous to sys_clk.
// Notes: Set beats clear so no fault is lost at a clear.
`timescale 1ns/1ps
module pss_latch_bit #(
    parameter RESET_VAL = 1'b0
) (
    input  wire sys_clk,
    input  wire reset_n,
    input  wire clk_en,
    input  wire fault_in,
    input  wire clear_req,
    output reg  flag_ff
);
    // Hold while the fault stands; drop only when gone and a clear arrives.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_ff <= RESET_VAL;
        end else if (clk_en) begin
            if (fault_in) begin
                flag_ff <= 1'b1;
            end else if (clear_req) begin
                flag_ff <= 1'b0;
            end
        end
    end
endmodule // pss_latch_bit

// ==== pss_status_bank.v ====
// Purpose: Status summary byte, word and output detail registers for a power switch.
// Assumes: A bus engine decodes commands and presents rd_cmd with a one-cycle rd_req.
// Assumes: Fault and detail inputs are levels synchronous to sys_clk.
// Notes: Read data answers one cycle after the request, as a registered word.
// Notes: Summary and output status flags are sticky; a flag drops only at a clear that finds its fault gone.
// Notes: Codes outside the four implemented ones answer zero and pulse rd_miss_ff.
//
// Behaviour
// - Read byte at 78h returns the critical fault summary byte.
// - Flags hold until fault is gone and the host clears faults; 7Bh bits are not latched and follow the live current lanes.
// - Byte: busy, gate off, two zeros, input UV, temp, CML, other.
// - Input undervoltage bit follows a detected input UV fault.
// - Read word at 79h returns the two-byte fault summary.
// - Word low byte is the same storage as the summary byte.
// - High byte: output, current, input, vendor summaries, power-good low, zeros.
// - Bit 0 and bit 8 flag events not covered elsewhere.
// - Read byte at 7Ah returns output status; bit 5 is UV warning.
// - Read byte at 7Bh returns output current status, summarized by bit 14.
`timescale 1ns/1ps
`include "pss_defines.vh"
module pss_status_bank (
    input  wire        sys_clk,
    input  wire        reset_n,
    input  wire        clk_en,
    input  wire        busy,
    input  wire        gate_drive_off,
    input  wire        input_undervolt_fault,
    input  wire [7:0]  temp_detail,
    input  wire [7:0]  cml_detail,
    input  wire        other_event,
    input  wire [7:0]  input_detail,
    input  wire [7:0]  vendor_detail,
    input  wire [7:0]  out_current_detail,
    input  wire        output_undervolt_warning,
    input  wire        power_good,
    input  wire        unknown_event,
    input  wire        clear_faults,
    input  wire        rd_req,
    input  wire [7:0]  rd_cmd,
    output reg  [15:0] rd_data_ff,
    output reg         rd_valid_ff,
    output reg         rd_miss_ff
);
    // Timing at a glance: a request taken at an enabled edge is answered by
    // rd_valid_ff and rd_data_ff just after that edge; valid and miss stand
    // for one cycle, the data until the next request. A fault seen at an
    // enabled edge shows in a read taken at the following edge. With clk_en
    // low every flop here keeps its value, so a frozen bank neither sets nor
    // clears a flag and answers no request.

    // Sixteen sticky cells form the summary word; the byte read is its low half.
    localparam NFLAGS = 16;
    // Width of one detail status register.
    localparam DWIDTH = 8;
    // Reset image of the word: only the power-good lane starts set, so the
    // supply reads as not yet good until a clear finds it good.
    localparam [NFLAGS-1:0] WORD_RESET = `PSS_WORD_RESET;

    // Read selects produced by the command decode below. The miss code sits
    // apart from the others so that a new code can be added without a clash.
    localparam [2:0] SEL_BYTE = 3'h0;
    localparam [2:0] SEL_WORD = 3'h1;
    localparam [2:0] SEL_OUT  = 3'h2;
    localparam [2:0] SEL_IOUT = 3'h3;
    localparam [2:0] SEL_NONE = 3'h7;

    // Command decode, shared by the data mux and the miss flag so that the
    // two can never disagree about which codes this bank implements.
    function [2:0] pss_cmd_sel;
        input [7:0] cmd;
        begin
            if (cmd == `PSS_CMD_SUMMARY_BYTE) begin
                pss_cmd_sel = SEL_BYTE;
            end else if (cmd == `PSS_CMD_SUMMARY_WORD) begin
                pss_cmd_sel = SEL_WORD;
            end else if (cmd == `PSS_CMD_OUTPUT_STAT) begin
                pss_cmd_sel = SEL_OUT;
            end else if (cmd == `PSS_CMD_OUT_CUR_STAT) begin
                pss_cmd_sel = SEL_IOUT;
            end else begin
                pss_cmd_sel = SEL_NONE;
            end
        end
    endfunction

    // Fault sources by word bit position, the latched flags, the output
    // and current detail lanes, and the sticky copy of the output lanes.
    wire [NFLAGS-1:0] fault_vec;
    wire [NFLAGS-1:0] flag_vec;
    wire [DWIDTH-1:0] out_detail;
    wire [DWIDTH-1:0] iout_detail;
    wire [DWIDTH-1:0] out_stat_vec;

    // Per-register summaries, kept as named nets so each word lane can be
    // matched to the detail register that it stands for.
    wire              temp_sum;
    wire              cml_sum;
    wire              out_sum;
    wire              iout_sum;
    wire              input_sum;
    wire              vendor_sum;

    // Output detail: only the UV warning lane is populated.
    assign out_detail  = {2'h0, output_undervolt_warning, 5'h00};
    // Current detail lanes come straight from the sensing logic.
    assign iout_detail = out_current_detail;

    // Each summary is the OR of its detail lanes, so one active lane is
    // enough. The OR is taken on the live lanes, so a summary sets in the
    // same cycle as the detail flag behind it.
    assign temp_sum   = |temp_detail;
    assign cml_sum    = |cml_detail;
    assign out_sum    = |out_detail;
    assign iout_sum   = |iout_detail;
    assign input_sum  = |input_detail;
    assign vendor_sum = |vendor_detail;

    // Low byte lanes: the critical fault summary. Lanes 5:4 are reserved and
    // tie low, so their cells never set and always read as zero.
    assign fault_vec[`PSS_BIT_BUSY]       = busy;
    assign fault_vec[`PSS_BIT_GATE_OFF]   = gate_drive_off;
    assign fault_vec[5:4]                 = 2'h0;
    assign fault_vec[`PSS_BIT_VIN_UV]     = input_undervolt_fault;
    assign fault_vec[`PSS_BIT_TEMP]       = temp_sum;
    assign fault_vec[`PSS_BIT_CML]        = cml_sum;
    assign fault_vec[`PSS_BIT_OTHER]      = other_event;

    // High byte lanes: detail summaries, power-good and the catch-all event.
    // Power-good is inverted here because the lane reports the low-active
    // state; lanes 10:9 are reserved and tie low.
    assign fault_vec[`PSS_BIT_OUT_SUM]    = out_sum;
    assign fault_vec[`PSS_BIT_IOUT_SUM]   = iout_sum;
    assign fault_vec[`PSS_BIT_INPUT_SUM]  = input_sum;
    assign fault_vec[`PSS_BIT_VENDOR_SUM] = vendor_sum;
    assign fault_vec[`PSS_BIT_PG_LOW]     = ~power_good;
    assign fault_vec[10:9]                = 2'h0;
    assign fault_vec[`PSS_BIT_UNKNOWN]    = unknown_event;

    // One sticky cell per word bit. A cell sets on its fault and drops only
    // at a clear that finds the fault gone; a clear that meets a standing
    // fault is lost for that cell, so the host must clear again. The
    // power-good cell takes its reset value from the word reset image.
    genvar gi;
    generate
        for (gi = 0; gi < NFLAGS; gi = gi + 1) begin : g_flag
            pss_latch_bit #(
                .RESET_VAL (WORD_RESET[gi])
            ) u_bit (
                .sys_clk   (sys_clk),
                .reset_n   (reset_n),
                .clk_en    (clk_en),
                .fault_in  (fault_vec[gi]),
                .clear_req (clear_faults),
                .flag_ff   (flag_vec[gi])
            );
        end
    endgenerate

    // Output status register: one sticky cell per lane so that a short
    // warning is still seen by a host that polls slowly. Reserved lanes are
    // fed a constant low and therefore always read as zero.
    genvar oi;
    generate
        for (oi = 0; oi < DWIDTH; oi = oi + 1) begin : g_out
            pss_latch_bit #(
                .RESET_VAL (1'b0)
            ) u_out_bit (
                .sys_clk   (sys_clk),
                .reset_n   (reset_n),
                .clk_en    (clk_en),
                .fault_in  (out_detail[oi]),
                .clear_req (clear_faults),
                .flag_ff   (out_stat_vec[oi])
            );
        end
    endgenerate

    // Read path nets; rd_sel is a plain decode, not a register.
    reg  [2:0]        rd_sel;
    reg  [15:0]       nxt_rd_data;
    wire              nxt_rd_miss;
    wire              nxt_rd_valid;

    // Read mux; the byte read and the word low byte share flag_vec[7:0], so
    // the two reads can never disagree. Unknown codes leave the data at zero.
    always @* begin
        rd_sel      = pss_cmd_sel(rd_cmd);
        nxt_rd_data = 16'h0000;
        if (rd_sel == SEL_BYTE) begin
            nxt_rd_data = {8'h00, flag_vec[7:0]};
        end else if (rd_sel == SEL_WORD) begin
            nxt_rd_data = flag_vec;
        end else if (rd_sel == SEL_OUT) begin
            nxt_rd_data = {8'h00, out_stat_vec};
        end else if (rd_sel == SEL_IOUT) begin
            nxt_rd_data = {8'h00, iout_detail};
        end
    end

    // The miss flag reuses the same decode as the mux, so a code that the
    // mux serves can never also be reported as a miss.
    assign nxt_rd_miss  = rd_req & (pss_cmd_sel(rd_cmd) == SEL_NONE);
    assign nxt_rd_valid = rd_req;

    // Registered answer. Data is only loaded on a request, so it stands
    // until the next one; valid and miss are rebuilt every enabled cycle
    // and so last exactly one.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_ff  <= 16'h0000;
            rd_valid_ff <= 1'b0;
            rd_miss_ff  <= 1'b0;
        end else if (clk_en) begin
            rd_valid_ff <= nxt_rd_valid;
            rd_miss_ff  <= nxt_rd_miss;
            if (rd_req) begin
                rd_data_ff <= nxt_rd_data;
            end
        end
    end
endmodule // pss_status_bank

// ==== pss_properties.sv ====
// Purpose: Port properties of the status bank.
// Assumes: Answers are registered one cycle after a taken request.
// Notes: Bound to every bank instance.
`timescale 1ns/1ps
module pss_properties (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        clk_en,
    input wire logic        input_undervolt_fault,
    input wire logic [7:0]  out_current_detail,
    input wire logic        rd_req,
    input wire logic [7:0]  rd_cmd,
    input wire logic [15:0] rd_data_ff,
    input wire logic        rd_valid_ff,
    input wire logic        rd_miss_ff
);
    // A request only counts on an enabled edge.
    wire take = clk_en && rd_req;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    property p_ans; take |=> rd_valid_ff; endproperty
    // A frozen edge keeps the last answer, so only an enabled idle edge must drop it.
    property p_quiet; clk_en && !rd_req |=> !rd_valid_ff && !rd_miss_ff; endproperty
    property p_miss; take && !(rd_cmd inside {[8'h78:8'h7b]}) |=> rd_miss_ff && rd_data_ff == 0; endproperty
    property p_hi; take && rd_cmd != 8'h79 |=> rd_data_ff[15:8] == 8'h00; endproperty
    property p_rsv; take && rd_cmd inside {8'h78, 8'h79} |=> rd_data_ff[5:4] == 0 && rd_data_ff[10:9] == 0; endproperty
    property p_out; take && rd_cmd == 8'h7a |=> (rd_data_ff & 16'hffdf) == 0; endproperty
    property p_iout; take && rd_cmd == 8'h7b |=> rd_data_ff[7:0] == $past(out_current_detail); endproperty
    property p_uv; clk_en && input_undervolt_fault ##1 take && rd_cmd == 8'h78 |=> rd_data_ff[3]; endproperty
    a_ans: assert property (p_ans) else $error("read not answered");
    a_quiet: assert property (p_quiet) else $error("answer without request");
    a_miss: assert property (p_miss) else $error("unknown code answered");
    a_hi: assert property (p_hi) else $error("byte read upper bits set");
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    a_out: assert property (p_out) else $error("output status reserved set");
    a_iout: assert property (p_iout) else $error("current status wrong");
    a_uv: assert property (p_uv) else $error("input UV not flagged");
    c_word: cover property (take && rd_cmd == 8'h79);
    c_miss: cover property (rd_miss_ff);
    c_uv: cover property (rd_valid_ff && rd_data_ff[3]);
endmodule // pss_properties
bind pss_status_bank pss_properties u_props (
    .sys_clk               (sys_clk),
    .reset_n               (reset_n),
    .clk_en                (clk_en),
    .input_undervolt_fault (input_undervolt_fault),
    .out_current_detail    (out_current_detail),
    .rd_req                (rd_req),
    .rd_cmd                (rd_cmd),
    .rd_data_ff            (rd_data_ff),
    .rd_valid_ff           (rd_valid_ff),
    .rd_miss_ff            (rd_miss_ff)
);

// ==== pss_host_model.sv ====
// Purpose: Host side that issues status reads.
// Assumes: The bank answers one cycle after the request.
// Notes: Released command lines show the inverse so stale values never pass.
`timescale 1ns/1ps
module pss_host_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] rd_data_ff,
    input  wire logic        rd_valid_ff,
    output logic             rd_req,
    output logic [7:0]       rd_cmd
);
    initial rd_req = 1'b0;
    initial rd_cmd = 8'h00;
    // One request cycle, then the answer is taken after its edge.
    task automatic rd(input logic [7:0] cmd, output logic [15:0] dat, output logic ok);
        @(negedge sys_clk);
        rd_req = 1'b1;
        rd_cmd = cmd;
        @(negedge sys_clk);
        rd_req = 1'b0;
        rd_cmd = ~cmd;
        ok = rd_valid_ff;
        dat = rd_data_ff;
    endtask
endmodule // pss_host_model

// ==== tb_pss_status_bank.sv ====
// Purpose: Self-checking bench for the status bank.
// Assumes: Inputs change on the falling edge.
// Notes: Only in the reset and summary tests is a summary read followed by output detail reads.
`timescale 1ns/1ps
module tb_pss_status_bank;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  td, cd, id, vd, od, rd_cmd;
    logic        bz, go, uv, oe, ue, ow, pg, clr, rd_req, rd_valid_ff;
    logic        en = 1'b1;
    logic        rd_miss;
    logic [15:0] rd_data_ff;
    int          failures = 0;
    int          checked = 0;
    always #5 sys_clk = ~sys_clk;
    pss_status_bank u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(en), .busy(bz),
        .gate_drive_off(go), .input_undervolt_fault(uv), .temp_detail(td), .cml_detail(cd),
        .other_event(oe), .input_detail(id), .vendor_detail(vd), .out_current_detail(od),
        .output_undervolt_warning(ow), .power_good(pg), .unknown_event(ue), .clear_faults(clr),
        .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff),
        .rd_miss_ff(rd_miss));
    pss_host_model u_host (.sys_clk(sys_clk), .rd_data_ff(rd_data_ff),
        .rd_valid_ff(rd_valid_ff), .rd_req(rd_req), .rd_cmd(rd_cmd));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
        logic [15:0] d;
        logic        v;
        logic        m;
        u_host.rd(cmd, d, v);
        m = rd_miss;
        chk({15'h0000, v}, 16'h0001);
        chk(d, exp);
        chk({15'h0000, m}, {15'h0000, !(cmd inside {8'h78, 8'h79, 8'h7a, 8'h7b})});
    endtask
    // Sources packed as busy, gate, uv, other, unknown, warn, good, clear, details.
    task automatic set(input logic [47:0] v);
        @(negedge sys_clk);
        {bz, go, uv, oe, ue, ow, pg, clr, td, cd, id, vd, od} = v;
    endtask
    task automatic end_of_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        {bz, go, uv, oe, ue, ow, pg, clr, td, cd, id, vd, od} = 48'h0;
        repeat (6) @(negedge sys_clk);
        reset_n = 1'b1;
        rd(8'h78, 16'h0000);
        rd(8'h79, 16'h0800);
        rd(8'h7a, 16'h0000);
        $display("test reset done");
        set(48'h2000_0000_0000);
        rd(8'h78, 16'h0008);
        rd(8'h79, 16'h0808);
        set(48'h2100_0000_0000);
        set(48'h0000_0000_0000);
        rd(8'h78, 16'h0008);
        set(48'h0100_0000_0000);
        set(48'h0000_0000_0000);
        rd(8'h79, 16'h0800);
        // A fault that comes and goes while the bank is frozen is not seen.
        @(negedge sys_clk);
        en = 1'b0;
        set(48'h2000_0000_0000);
        set(48'h0000_0000_0000);
        @(negedge sys_clk);
        en = 1'b1;
        rd(8'h78, 16'h0000);
        $display("test sticky done");
        set(48'hfe01_8004_105a);
        rd(8'h79, 16'hf9cf);
        rd(8'h7a, 16'h0020);
        rd(8'h7b, 16'h005a);
        rd(8'h7c, 16'h0000);
        set(48'h0300_0000_0000);
        set(48'h0200_0000_0000);
        rd(8'h79, 16'h0000);
        $display("test summary done");
        end_of_test();
    end
endmodule // tb_pss_status_bank
